// ==== osw_osc_ctrl.sv ====
// Oscillator control register with switch request and clock fail flag
//
// Contract
// - Monitor failure sets clock fail flag bit 3.
// - Writing switch request starts switch to new source.
// - Switch request reads 0 once switch finishes.
// - Control register writes need an unlock sequence.
// - No direct switch between the two PLL modes.
// - Software writing fail flag 1 acts as failure.
// - Bits 4, 2 and 1 read as zero.
`timescale 1ns/1ps
module osw_osc_ctrl #(
    parameter int SWITCH_CYCLES = osw_pkg::SWITCH_CYCLES,
    parameter osw_pkg::osw_src_t RESET_SOURCE = osw_pkg::RST_SOURCE
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire osw_pkg::osw_bus_req_t bus_i,
    input wire logic fail_detect_i,
    output osw_pkg::osw_data_t rd_data_o,
    output logic irq_o,
    output logic osc_fail_trap_o,
    output osw_pkg::osw_src_t active_source_o
);
    import osw_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    osw_ctrl_st_t st;
    osw_ctrl_st_t next_st;

    // Sequencer answers
    osw_src_t act_source;
    logic sw_done;
    logic sw_refused;

    // Decoded bus access
    logic wr_osc;
    logic wr_unlock;
    logic wr_mask;
    logic osc_wr_ok;
    logic osc_wr_bad;
    logic sw_fail_write;
    logic status_clear;

    // Events of this cycle
    osw_ev_t ev;

    // ------------------------------------------------------------
    // Switch sequencer
    // ------------------------------------------------------------
    // Kept apart so the hop check sits beside the live source
    osw_switcher #(
        .SWITCH_CYCLES(SWITCH_CYCLES),
        .RESET_SOURCE(RESET_SOURCE)
    ) u_switcher (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .start_i(st.start),
        .target_i(st.new_source),
        .source_o(act_source),
        .done_o(sw_done),
        .refused_o(sw_refused)
    );

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    // Control word as software sees it
    function automatic osw_data_t osc_view(input osw_ctrl_st_t s,
                                           input osw_src_t act);
        osw_data_t v;
        v = '0;
        v[ACT_SRC_LSB +: SRC_W] = act;
        v[NEW_SRC_LSB +: SRC_W] = s.new_source;
        v[BIT_CLOCK_FAIL] = s.clock_fail;
        v[BIT_SWITCH_REQ] = s.switch_req;
        osc_view = v;
    endfunction : osc_view

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Write strobes per register, plus the status read-clear strobe
    always_comb begin
        wr_osc = bus_i.wr && (bus_i.addr == OFS_OSC_CTRL);
        wr_unlock = bus_i.wr && (bus_i.addr == OFS_UNLOCK);
        wr_mask = bus_i.wr && (bus_i.addr == OFS_IRQ_MASK);
        osc_wr_ok = wr_osc && (st.unlock == UNL_OPEN);
        osc_wr_bad = wr_osc && (st.unlock != UNL_OPEN);
        sw_fail_write = osc_wr_ok && bus_i.wdata[BIT_CLOCK_FAIL];
        status_clear = bus_i.rd && (bus_i.addr == OFS_IRQ_STATUS);
    end

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    // One bit per event, pulse wide
    always_comb begin
        ev = '0;
        ev[EV_CLOCK_FAIL] = fail_detect_i || sw_fail_write;
        ev[EV_SWITCH_DONE] = sw_done;
        ev[EV_SWITCH_REFUSED] = sw_refused;
        ev[EV_WRITE_REFUSED] = osc_wr_bad;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Whole control state in one pass
    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.trap = 1'b0;
        next_st.rd_data = '0;

        // Unlock walk; any other write closes it again
        if (bus_i.wr) begin
            unique case (st.unlock)
                UNL_IDLE: begin
                    if (wr_unlock && bus_i.wdata == KEY_FIRST) begin
                        next_st.unlock = UNL_KEY1;
                    end
                end
                UNL_KEY1: begin
                    if (wr_unlock && bus_i.wdata == KEY_SECOND) begin
                        next_st.unlock = UNL_OPEN;
                    end else begin
                        next_st.unlock = UNL_IDLE;
                    end
                end
                UNL_OPEN: begin
                    next_st.unlock = UNL_IDLE;
                end
            endcase
        end

        // Accepted control write; source frozen while switching
        if (osc_wr_ok) begin
            if (!st.switch_req) begin
                next_st.new_source =
                    bus_i.wdata[NEW_SRC_LSB +: SRC_W];
            end
            if (bus_i.wdata[BIT_SWITCH_REQ] && !st.switch_req) begin
                next_st.switch_req = 1'b1;
                next_st.start = 1'b1;
            end
            // Software owns the clear of the flag
            next_st.clock_fail = bus_i.wdata[BIT_CLOCK_FAIL];
        end

        // Software set behaves as a real failure
        if (sw_fail_write) begin
            next_st.trap = 1'b1;
        end

        // Monitor failure wins over a same cycle clear
        if (fail_detect_i) begin
            next_st.clock_fail = 1'b1;
            next_st.trap = 1'b1;
        end

        // Request drops when the sequencer ends, either way
        if (sw_done || sw_refused) begin
            next_st.switch_req = 1'b0;
        end

        // Mask needs no unlock
        if (wr_mask) begin
            next_st.mask = bus_i.wdata[EV_W-1:0];
        end

        // Read data, valid only in the following cycle
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                OFS_OSC_CTRL: begin
                    next_st.rd_data = osc_view(st, act_source);
                end
                OFS_IRQ_STATUS: begin
                    next_st.rd_data[EV_W-1:0] = st.status;
                end
                OFS_IRQ_MASK: begin
                    next_st.rd_data[EV_W-1:0] = st.mask;
                end
                default: begin
                    next_st.rd_data = '0; // Unmapped and unlock read 0
                end
            endcase
        end

        // Read clears, a new event in the same cycle survives
        next_st.status = (status_clear ? '0 : st.status) | ev;

        // Level interrupt follows the registered status
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset to constants only
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '{unlock: UNL_IDLE, new_source: RESET_SOURCE,
                    switch_req: 1'b0, clock_fail: 1'b0,
                    start: 1'b0, status: '0, mask: RST_MASK,
                    rd_data: '0, irq: 1'b0, trap: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All straight from flip-flops
    assign rd_data_o = st.rd_data;
    assign irq_o = st.irq;
    assign osc_fail_trap_o = st.trap;
    assign active_source_o = act_source;

endmodule : osw_osc_ctrl

// ==== osw_osc_ctrl_asserts.sv ====
// Checker for the oscillator control register block, bound to its ports
`timescale 1ns/1ps
module osw_osc_ctrl_chk
    import osw_pkg::*;
#(
    parameter int SWITCH_CYCLES = osw_pkg::SWITCH_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire osw_pkg::osw_bus_req_t bus_i,
    input wire logic fail_detect_i,
    input wire osw_pkg::osw_data_t rd_data_o,
    input wire logic irq_o,
    input wire logic osc_fail_trap_o,
    input wire osw_pkg::osw_src_t active_source_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_fail_trap;
        fail_detect_i |=> osc_fail_trap_o;
    endproperty
    a_fail_trap: assert property (p_fail_trap)
        else $error("trap missing after monitor failure");

    // Trap only from a failure or a write with the flag bit set
    property p_trap_cause;
        osc_fail_trap_o |-> $past(fail_detect_i) || ($past(bus_i.wr)
            && $past(bus_i.addr) == OFS_OSC_CTRL
            && $past(bus_i.wdata[BIT_CLOCK_FAIL]));
    endproperty
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap without a cause");

    property p_rd_idle;
        !bus_i.rd |=> rd_data_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read answer");

    property p_unimpl;
        bus_i.rd && bus_i.addr == OFS_OSC_CTRL
            |=> rd_data_o[4] == 1'b0 && rd_data_o[2:1] == 2'b00;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented control bits not zero");

    property p_unmapped;
        bus_i.rd && bus_i.addr > OFS_IRQ_MASK |=> rd_data_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // Never a direct step between the two PLL sources
    property p_no_pll_hop;
        !(($past(active_source_o) == SRC_RC_PLL
            && active_source_o == SRC_PRIMARY_PLL)
          || ($past(active_source_o) == SRC_PRIMARY_PLL
            && active_source_o == SRC_RC_PLL));
    endproperty
    a_no_pll_hop: assert property (p_no_pll_hop)
        else $error("direct switch between PLL sources");

    property p_fail_read;
        fail_detect_i ##1 (bus_i.rd && bus_i.addr == OFS_OSC_CTRL)
            |=> rd_data_o[BIT_CLOCK_FAIL];
    endproperty
    a_fail_read: assert property (p_fail_read)
        else $error("fail flag not read back after failure");

    property p_mask_rd;
        (bus_i.wr && bus_i.addr == OFS_IRQ_MASK)
            ##1 (bus_i.rd && bus_i.addr == OFS_IRQ_MASK)
            |=> rd_data_o == {12'h000, $past(bus_i.wdata[EV_W-1:0], 2)};
    endproperty
    a_mask_rd: assert property (p_mask_rd)
        else $error("mask read back differs from write");

    // Cycles since the active source last moved, capped to stay small
    osw_src_t prev_src;
    int since_move;
    always_ff @(posedge ref_clk_i) begin
        prev_src <= active_source_o;
        if (!rstn_i || prev_src != active_source_o) begin
            since_move <= 0;
        end else if (since_move < 1000) begin
            since_move <= since_move + 1;
        end
    end

    // A finished switch spans at least the sequencer's run time
    property p_switch_gap;
        prev_src != active_source_o |-> since_move >= SWITCH_CYCLES;
    endproperty
    a_switch_gap: assert property (p_switch_gap)
        else $error("active source moved too soon after the last move");

    // Main scenarios reached
    c_trap: cover property (osc_fail_trap_o);
    c_irq: cover property ($rose(irq_o));
    c_switch: cover property ($changed(active_source_o));
endmodule : osw_osc_ctrl_chk

bind osw_osc_ctrl osw_osc_ctrl_chk #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
    .fail_detect_i(fail_detect_i), .rd_data_o(rd_data_o), .irq_o(irq_o),
    .osc_fail_trap_o(osc_fail_trap_o), .active_source_o(active_source_o));

// ==== osw_osc_ctrl_bench.sv ====
// Self-checking bench of the oscillator control register block
`timescale 1ns/1ps
module osw_osc_ctrl_bench;
    import osw_pkg::*;
    // Short switch time keeps the run brief
    localparam int SW_CYC = 3;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    osw_bus_req_t bus_i = '0;
    logic fail_detect_i = 1'b0;
    osw_data_t rd_data_o;
    logic irq_o;
    logic osc_fail_trap_o;
    osw_src_t active_source_o;
    int bad_count = 0;
    int cmp_count = 0;
    osw_src_t cur_src = RST_SOURCE;
    osw_src_t cur_new = RST_SOURCE;

    always #20 ref_clk_i = ~ref_clk_i;

    osw_osc_ctrl #(.SWITCH_CYCLES(SW_CYC), .RESET_SOURCE(RST_SOURCE)) DUT (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
        .fail_detect_i(fail_detect_i), .rd_data_o(rd_data_o),
        .irq_o(irq_o), .osc_fail_trap_o(osc_fail_trap_o),
        .active_source_o(active_source_o));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    task cmp16(input string what, input osw_data_t exp, input osw_data_t got);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : cmp16

    task cmp1(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %s expected %b seen %b", what, exp, got);
            bad_count++;
        end
    endtask : cmp1

    // One strobe per edge; a following call overwrites it
    task bus_op(input logic w, input logic r, input osw_addr_t a,
                input osw_data_t d);
        @(posedge ref_clk_i);
        bus_i <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : bus_op

    task wr(input osw_addr_t a, input osw_data_t d);
        bus_op(1'b1, 1'b0, a, d);
    endtask : wr

    // Data stand only in the cycle after the strobe
    task rd(input osw_addr_t a, output osw_data_t d);
        bus_op(1'b0, 1'b1, a, 16'h0000);
        @(posedge ref_clk_i);
        bus_i <= '0;
        #1;
        d = rd_data_o;
    endtask : rd

    task chk_rd(input string what, input osw_addr_t a, input osw_data_t exp);
        osw_data_t d;
        rd(a, d);
        cmp16(what, exp, d);
    endtask : chk_rd

    task unl_wr(input osw_data_t d);
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_OSC_CTRL, d);
    endtask : unl_wr

    function automatic osw_data_t cword(osw_src_t act, osw_src_t nw,
                                        logic cf, logic sw);
        osw_data_t w;
        w = 16'h0000;
        w[ACT_SRC_LSB +: SRC_W] = act;
        w[NEW_SRC_LSB +: SRC_W] = nw;
        w[BIT_CLOCK_FAIL] = cf;
        w[BIT_SWITCH_REQ] = sw;
        return w;
    endfunction : cword

    task do_reset;
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        cur_src = RST_SOURCE;
        cur_new = RST_SOURCE;
    endtask : do_reset

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        chk_rd("ctrl", OFS_OSC_CTRL, cword(cur_src, cur_new, 1'b0, 1'b0));
        chk_rd("status", OFS_IRQ_STATUS, 16'h0000);
        chk_rd("mask", OFS_IRQ_MASK, 16'h0000);
        cmp1("irq", 1'b0, irq_o);
        $display("test reset done");
    endtask : t_reset

    // Missing, wrong or stale keys all leave the register alone
    task t_locked;
        wr(OFS_IRQ_MASK, 16'h000f);
        chk_rd("mask", OFS_IRQ_MASK, 16'h000f);
        wr(OFS_OSC_CTRL, cword(3'h0, SRC_PRIMARY, 1'b1, 1'b1));
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, 16'h1234);
        wr(OFS_OSC_CTRL, cword(3'h0, SRC_PRIMARY, 1'b1, 1'b1));
        wr(OFS_UNLOCK, KEY_FIRST);
        wr(OFS_UNLOCK, KEY_SECOND);
        wr(OFS_IRQ_MASK, 16'h000f);
        wr(OFS_OSC_CTRL, cword(3'h0, SRC_PRIMARY, 1'b1, 1'b1));
        chk_rd("ctrl", OFS_OSC_CTRL,
               cword(cur_src, cur_new, 1'b0, 1'b0));
        cmp1("irq", 1'b1, irq_o);
        chk_rd("status", OFS_IRQ_STATUS, 16'h0008);
        repeat (2) @(posedge ref_clk_i);
        #1;
        cmp1("irq", 1'b0, irq_o);
        $display("test locked done");
    endtask : t_locked

    // Table walks every source code, two forbidden hops among them
    task t_switch;
        osw_src_t tg [6] = '{SRC_PRIMARY, SRC_PRIMARY_PLL, SRC_RC_PLL,
                             SRC_FAST_RC, SRC_RC_PLL, SRC_PRIMARY_PLL};
        osw_src_t ex [6] = '{SRC_PRIMARY, SRC_PRIMARY_PLL, SRC_PRIMARY_PLL,
                             SRC_FAST_RC, SRC_RC_PLL, SRC_RC_PLL};
        int ev [6] = '{EV_SWITCH_DONE, EV_SWITCH_DONE, EV_SWITCH_REFUSED,
                       EV_SWITCH_DONE, EV_SWITCH_DONE, EV_SWITCH_REFUSED};
        osw_data_t d;
        int n;
        for (int i = 0; i < 6; i++) begin
            unl_wr(cword(3'h0, tg[i], 1'b0, 1'b1));
            rd(OFS_OSC_CTRL, d);
            if (ev[i] == EV_SWITCH_DONE) begin
                cmp1("switch busy", 1'b1, d[BIT_SWITCH_REQ]);
            end
            n = 0;
            while (d[BIT_SWITCH_REQ] !== 1'b0 && n < 20) begin
                rd(OFS_OSC_CTRL, d);
                n++;
            end
            if (n == 20) begin
                $display("ERROR switch end expected 0 seen %b", d[0]);
                bad_count++;
                give_verdict;
            end
            cur_src = ex[i];
            cur_new = tg[i];
            cmp16("ctrl", cword(ex[i], tg[i], 1'b0, 1'b0), d);
            cmp16("source", {13'h0000, ex[i]},
                  {13'h0000, active_source_o});
            chk_rd("status", OFS_IRQ_STATUS, 16'h0001 << ev[i]);
        end
        $display("test switch done");
    endtask : t_switch

    task t_fail;
        @(posedge ref_clk_i);
        fail_detect_i <= 1'b1;
        @(posedge ref_clk_i);
        fail_detect_i <= 1'b0;
        bus_i <= '{addr: OFS_OSC_CTRL, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        #1;
        cmp1("trap", 1'b1, osc_fail_trap_o);
        @(posedge ref_clk_i);
        bus_i <= '0;
        #1;
        cmp16("ctrl", cword(cur_src, cur_new, 1'b1, 1'b0), rd_data_o);
        cmp1("irq", 1'b1, irq_o);
        chk_rd("status", OFS_IRQ_STATUS, 16'h0001);
        // Software clear, with unimplemented bits written as ones
        unl_wr(cword(3'h0, cur_new, 1'b0, 1'b0) | 16'h0016);
        chk_rd("ctrl", OFS_OSC_CTRL,
               cword(cur_src, cur_new, 1'b0, 1'b0));
        unl_wr(cword(3'h0, cur_new, 1'b1, 1'b0));
        @(posedge ref_clk_i);
        bus_i <= '0;
        #1;
        cmp1("trap", 1'b1, osc_fail_trap_o);
        chk_rd("ctrl", OFS_OSC_CTRL,
               cword(cur_src, cur_new, 1'b1, 1'b0));
        chk_rd("status", OFS_IRQ_STATUS, 16'h0001);
        $display("test fail done");
    endtask : t_fail

    task t_unmapped;
        wr(4'h7, 16'hffff);
        chk_rd("unmapped", 4'h7, 16'h0000);
        chk_rd("unlock", OFS_UNLOCK, 16'h0000);
        $display("test unmapped done");
    endtask : t_unmapped

    // ------------------------------------------------------------
    // Main sequence, mid-run reset at the end
    // ------------------------------------------------------------
    initial begin
        do_reset;
        t_reset;
        t_locked;
        t_switch;
        t_fail;
        t_unmapped;
        do_reset;
        t_reset;
        give_verdict;
    end
endmodule : osw_osc_ctrl_bench

// ==== osw_pkg.sv ====
// Constants and types of the oscillator switch and fail flag block
package osw_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    typedef logic [ADDR_W-1:0] osw_addr_t;
    typedef logic [DATA_W-1:0] osw_data_t;

    // Request from the register master
    typedef struct packed {
        osw_addr_t addr;
        osw_data_t wdata;
        logic wr;
        logic rd;
    } osw_bus_req_t;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam osw_addr_t OFS_OSC_CTRL = 4'h0;
    localparam osw_addr_t OFS_UNLOCK = 4'h1;
    localparam osw_addr_t OFS_IRQ_STATUS = 4'h2;
    localparam osw_addr_t OFS_IRQ_MASK = 4'h3;

    // ------------------------------------------------------------
    // Field positions of oscillator_control
    // ------------------------------------------------------------
    localparam int BIT_SWITCH_REQ = 0;
    localparam int BIT_CLOCK_FAIL = 3;
    localparam int SRC_W = 3;
    localparam int NEW_SRC_LSB = 8;
    localparam int ACT_SRC_LSB = 12;

    // ------------------------------------------------------------
    // Oscillator source codes
    // ------------------------------------------------------------
    typedef logic [SRC_W-1:0] osw_src_t;
    localparam osw_src_t SRC_FAST_RC = 3'h0;
    localparam osw_src_t SRC_RC_PLL = 3'h1;
    localparam osw_src_t SRC_PRIMARY = 3'h2;
    localparam osw_src_t SRC_PRIMARY_PLL = 3'h3;
    localparam osw_src_t RST_SOURCE = SRC_FAST_RC;

    // ------------------------------------------------------------
    // Unlock keys, values arbitrary
    // ------------------------------------------------------------
    localparam osw_data_t KEY_FIRST = 16'h00a5;
    localparam osw_data_t KEY_SECOND = 16'h005a;

    // ------------------------------------------------------------
    // Interrupt events
    // ------------------------------------------------------------
    localparam int EV_W = 4;
    localparam int EV_CLOCK_FAIL = 0;
    localparam int EV_SWITCH_DONE = 1;
    localparam int EV_SWITCH_REFUSED = 2;
    localparam int EV_WRITE_REFUSED = 3;
    typedef logic [EV_W-1:0] osw_ev_t;
    localparam osw_ev_t RST_MASK = 4'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SWITCH_TIME_NS = 1000;
    localparam int SWITCH_RAW =
        (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_CYCLES = (SWITCH_RAW < 1) ? 1 : SWITCH_RAW;
    localparam int CNT_W = 12;
    typedef logic [CNT_W-1:0] osw_cnt_t;

    // ------------------------------------------------------------
    // State types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} osw_unlock_t;
    typedef enum logic {SW_IDLE, SW_RUN} osw_phase_t;

    // Control state of the register side
    typedef struct packed {
        osw_unlock_t unlock;
        osw_src_t new_source;
        logic switch_req;
        logic clock_fail;
        logic start;
        osw_ev_t status;
        osw_ev_t mask;
        osw_data_t rd_data;
        logic irq;
        logic trap;
    } osw_ctrl_st_t;

    // State of the switch sequencer
    typedef struct packed {
        osw_phase_t phase;
        osw_cnt_t count;
        osw_src_t source;
        osw_src_t target;
        logic done;
        logic refused;
    } osw_sw_st_t;

endpackage : osw_pkg

// ==== osw_switcher.sv ====
// Oscillator switch sequencer with forbidden path check
`timescale 1ns/1ps
module osw_switcher #(
    parameter int SWITCH_CYCLES = osw_pkg::SWITCH_CYCLES,
    parameter osw_pkg::osw_src_t RESET_SOURCE = osw_pkg::RST_SOURCE
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire osw_pkg::osw_src_t target_i,
    output osw_pkg::osw_src_t source_o,
    output logic done_o,
    output logic refused_o
);
    import osw_pkg::*;

    osw_sw_st_t st;
    osw_sw_st_t next_st;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // PLL to PLL hop has no safe direct path
    function automatic logic pll_hop(input osw_src_t a,
                                     input osw_src_t b);
        pll_hop = (a == SRC_PRIMARY_PLL && b == SRC_RC_PLL) ||
                  (a == SRC_RC_PLL && b == SRC_PRIMARY_PLL);
    endfunction : pll_hop

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state of the sequencer
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.refused = 1'b0;
        unique case (st.phase)
            SW_IDLE: begin
                if (start_i) begin
                    if (pll_hop(st.source, target_i)) begin
                        next_st.refused = 1'b1;
                    end else begin
                        next_st.target = target_i;
                        next_st.count = CNT_W'(SWITCH_CYCLES - 1);
                        next_st.phase = SW_RUN;
                    end
                end
            end
            SW_RUN: begin
                if (st.count == '0) begin
                    next_st.source = st.target;
                    next_st.done = 1'b1;
                    next_st.phase = SW_IDLE;
                end else begin
                    next_st.count = st.count - 1'b1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st <= '{phase: SW_IDLE, count: '0, source: RESET_SOURCE,
                    target: RESET_SOURCE, done: 1'b0, refused: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign source_o = st.source;
    assign done_o = st.done;
    assign refused_o = st.refused;

endmodule : osw_switcher
